// >>> design/bit_test_skip_call_exec.sv
// Execution sequencer for bit test, skip, test-and-set and subroutine calls
`timescale 1ns/1ns

module bit_test_skip_call_exec #(
   parameter int DATA_W   = bitcall_pkg::DATA_W,
   parameter int BITSEL_W = bitcall_pkg::BITSEL_W
) (
   input  wire logic                               CLK_SYS_I,
   input  wire logic                               ARST_N_I,
   input  wire logic                               CE_I,
   input  wire logic                               ISSUE_VALID_I,
   output logic                                    ISSUE_READY_O,
   input  wire bitcall_pkg::op_t                   ISSUE_OP_I,
   input  wire logic [BITSEL_W-1:0]                BIT_SEL_I,
   input  wire logic [DATA_W-1:0]                  OPERAND_I,
   input  wire logic [bitcall_pkg::HI_W-1:0]       OPERAND_HI_I,
   input  wire logic                               OPERAND_IS_SFR_I,
   input  wire logic                               NEXT_TWO_WORD_I,
   input  wire logic [DATA_W-1:0]                  LIT_LO_I,
   input  wire logic [bitcall_pkg::HI_W-1:0]       LIT_HI_I,
   output logic                                    DONE_O,
   output logic [1:0]                              WORDS_O,
   output logic                                    SKIP_O,
   output logic [1:0]                              SKIP_WORDS_O,
   output logic                                    REG_WE_O,
   output logic [DATA_W-1:0]                       REG_WDATA_O,
   output logic                                    CARRY_WE_O,
   output logic                                    CARRY_O,
   output logic                                    ZERO_WE_O,
   output logic                                    ZERO_O,
   output logic                                    SFA_SET_O,
   output logic                                    PC_LOAD_O,
   output logic [bitcall_pkg::TARGET_W-1:0]        PC_TARGET_O
);

   // ==========================================================================
   // Elaboration check
   // ==========================================================================
   if (DATA_W != bitcall_pkg::DATA_W || BITSEL_W != bitcall_pkg::BITSEL_W) begin : g_bad
      $error("bit_test_skip_call_exec: widths must match the core datapath");
   end

   // ==========================================================================
   // Declarations
   // ==========================================================================
   bitcall_pkg::state_t                state_r;
   logic [bitcall_pkg::CNT_W-1:0]      cnt_r;
   logic [bitcall_pkg::CNT_W-1:0]      cnt_nxt;
   logic                               take;
   logic                               tested_bit;
   logic [DATA_W-1:0]                  set_value;
   logic                               is_skip_op;
   logic                               is_tset_op;
   logic                               is_call_op;
   logic                               skip_now;
   logic                               reg_we_r;
   logic                               carry_we_r;
   logic                               zero_we_r;
   logic                               call_r;
   logic                               skip_r;

   // ==========================================================================
   // Bit selection
   // ==========================================================================
   bit_pick_set #(
      .WIDTH (DATA_W),
      .SEL_W (BITSEL_W)
   ) u_pick (
      .value_i (OPERAND_I),
      .sel_i   (BIT_SEL_I),
      .bit_o   (tested_bit),
      .set_o   (set_value)
   );

   // ==========================================================================
   // Issue decode
   // ==========================================================================
   // Handshake is combinational so one-cycle ops can issue back to back
   assign DONE_O        = (state_r == bitcall_pkg::ST_RUN) && (cnt_r == bitcall_pkg::RST_CNT);
   assign ISSUE_READY_O = (state_r == bitcall_pkg::ST_IDLE) || DONE_O;
   assign take          = CE_I && ISSUE_VALID_I && ISSUE_READY_O;

   assign is_skip_op = (ISSUE_OP_I == bitcall_pkg::OP_BIT_TEST_SKIP_CLEAR)
                    || (ISSUE_OP_I == bitcall_pkg::OP_BIT_TEST_SKIP_SET);
   assign is_tset_op = (ISSUE_OP_I == bitcall_pkg::OP_TEST_SET_TO_CARRY)
                    || (ISSUE_OP_I == bitcall_pkg::OP_TEST_SET_TO_ZERO);
   assign is_call_op = !is_skip_op && !is_tset_op;

   // Skip on a clear bit or on a set bit, according to the op
   always_comb begin
      skip_now = 1'b0;
      if (ISSUE_OP_I == bitcall_pkg::OP_BIT_TEST_SKIP_CLEAR) begin
         skip_now = !tested_bit;
      end else if (ISSUE_OP_I == bitcall_pkg::OP_BIT_TEST_SKIP_SET) begin
         skip_now = tested_bit;
      end
   end

   // Cycles remaining after the first, loaded when an op is taken
   always_comb begin
      logic [bitcall_pkg::CNT_W-1:0] total;
      total = bitcall_pkg::CYC_NO_SKIP;
      if (is_call_op) begin
         total = bitcall_pkg::CYC_CALL;
      end else if (skip_now) begin
         // The skipped word or words are fetched and discarded
         total = NEXT_TWO_WORD_I ? bitcall_pkg::CYC_SKIP_TWO
                                 : bitcall_pkg::CYC_SKIP_ONE;
      end
      if (!is_call_op && OPERAND_IS_SFR_I) begin
         // Peripheral registers sit behind a slower bus
         total = total + bitcall_pkg::CYC_SFR_EXTRA;
      end
      cnt_nxt = total - bitcall_pkg::CYC_NO_SKIP;
   end

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_r <= bitcall_pkg::ST_IDLE;
         cnt_r   <= bitcall_pkg::RST_CNT;
      end else if (CE_I) begin
         unique case (state_r)
            bitcall_pkg::ST_IDLE: begin
               if (take) begin
                  state_r <= bitcall_pkg::ST_RUN;
                  cnt_r   <= cnt_nxt;
               end
            end
            bitcall_pkg::ST_RUN: begin
               if (take) begin
                  cnt_r <= cnt_nxt;
               end else if (DONE_O) begin
                  state_r <= bitcall_pkg::ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - bitcall_pkg::CYC_NO_SKIP;
               end
            end
            default: begin
               state_r <= bitcall_pkg::ST_IDLE;
               cnt_r   <= bitcall_pkg::RST_CNT;
            end
         endcase
      end
   end

   // ==========================================================================
   // Result registers, captured when an op is taken
   // ==========================================================================
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         reg_we_r     <= 1'b0;
         carry_we_r   <= 1'b0;
         zero_we_r    <= 1'b0;
         call_r       <= 1'b0;
         skip_r       <= 1'b0;
         WORDS_O      <= bitcall_pkg::WORDS_ONE;
         SKIP_WORDS_O <= 2'h0;
         REG_WDATA_O  <= bitcall_pkg::RST_DATA;
         CARRY_O      <= 1'b0;
         ZERO_O       <= 1'b0;
         PC_TARGET_O  <= bitcall_pkg::RST_TARGET;
      end else if (take) begin
         // Skip ops leave every flag alone
         reg_we_r     <= is_tset_op;
         carry_we_r   <= (ISSUE_OP_I == bitcall_pkg::OP_TEST_SET_TO_CARRY);
         zero_we_r    <= (ISSUE_OP_I == bitcall_pkg::OP_TEST_SET_TO_ZERO);
         call_r       <= is_call_op;
         skip_r       <= skip_now;
         SKIP_WORDS_O <= !skip_now ? 2'h0
                       : NEXT_TWO_WORD_I ? bitcall_pkg::WORDS_TWO
                       : bitcall_pkg::WORDS_ONE;
         WORDS_O      <= (ISSUE_OP_I == bitcall_pkg::OP_CALL_LITERAL) ?
                         bitcall_pkg::WORDS_TWO : bitcall_pkg::WORDS_ONE;
         REG_WDATA_O  <= set_value;
         CARRY_O      <= tested_bit;
         ZERO_O       <= !tested_bit;
         // Short indirect calls reach only the low 64K words
         unique case (ISSUE_OP_I)
            bitcall_pkg::OP_CALL_LITERAL:
               PC_TARGET_O <= {LIT_HI_I, LIT_LO_I};
            bitcall_pkg::OP_CALL_INDIRECT_LONG:
               PC_TARGET_O <= {OPERAND_HI_I, OPERAND_I};
            default:
               PC_TARGET_O <= {{bitcall_pkg::HI_W{1'b0}}, OPERAND_I};
         endcase
      end
   end

   // ==========================================================================
   // Strobes, valid only in the finishing cycle
   // ==========================================================================
   assign REG_WE_O   = DONE_O && reg_we_r;
   assign CARRY_WE_O = DONE_O && carry_we_r;
   assign ZERO_WE_O  = DONE_O && zero_we_r;
   assign SFA_SET_O  = DONE_O && call_r;
   assign PC_LOAD_O  = DONE_O && call_r;
   assign SKIP_O     = DONE_O && skip_r;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   sequence take_s(bitcall_pkg::op_t op);
      take && ISSUE_OP_I == op && !OPERAND_IS_SFR_I;
   endsequence

   sequence call_run_s;
      ##1 (!DONE_O)[*3] ##1 DONE_O;
   endsequence

   noskip_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take_s(bitcall_pkg::OP_BIT_TEST_SKIP_CLEAR) ##0 tested_bit
      |-> ##1 DONE_O && !SKIP_O && !CARRY_WE_O && !ZERO_WE_O)
      else $error("clear test without skip did not finish in one cycle");

   skip_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take_s(bitcall_pkg::OP_BIT_TEST_SKIP_CLEAR) ##0 (!tested_bit && !NEXT_TWO_WORD_I)
      |-> ##1 !DONE_O ##1 DONE_O && SKIP_O && SKIP_WORDS_O == 2'h1)
      else $error("clear test skip over one word did not take two cycles");

   skip_set_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take_s(bitcall_pkg::OP_BIT_TEST_SKIP_SET) ##0 (tested_bit && NEXT_TWO_WORD_I)
      |-> ##1 (!DONE_O)[*2] ##1 DONE_O && SKIP_O && SKIP_WORDS_O == 2'h2)
      else $error("set test skip over two words did not take three cycles");

   noskip_set_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take_s(bitcall_pkg::OP_BIT_TEST_SKIP_SET) ##0 !tested_bit
      |-> ##1 DONE_O && !SKIP_O && !REG_WE_O && !ZERO_WE_O && !CARRY_WE_O)
      else $error("set test without skip misbehaved");

   carry_copy_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take_s(bitcall_pkg::OP_TEST_SET_TO_CARRY)
      |-> ##1 DONE_O && CARRY_WE_O && !ZERO_WE_O && REG_WE_O
          && CARRY_O == $past(tested_bit) && REG_WDATA_O[$past(BIT_SEL_I)])
      else $error("carry test-and-set result wrong");

   zero_load_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take_s(bitcall_pkg::OP_TEST_SET_TO_ZERO)
      |-> ##1 DONE_O && ZERO_WE_O && !CARRY_WE_O && REG_WE_O
          && ZERO_O == !$past(tested_bit) && REG_WDATA_O[$past(BIT_SEL_I)])
      else $error("zero test-and-set result wrong");

   call_four_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take && ISSUE_OP_I == bitcall_pkg::OP_CALL_LITERAL
      |-> call_run_s ##0 (PC_LOAD_O && SFA_SET_O && WORDS_O == 2'h2 && !CARRY_WE_O))
      else $error("literal call did not finish in four cycles");

   call_ind_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take && ISSUE_OP_I == bitcall_pkg::OP_CALL_INDIRECT
      |-> call_run_s ##0 (PC_LOAD_O && WORDS_O == 2'h1
          && PC_TARGET_O[15:0] == $past(OPERAND_I, 4)))
      else $error("indirect call target or timing wrong");

   sfr_extra_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      take && OPERAND_IS_SFR_I && ISSUE_OP_I == bitcall_pkg::OP_TEST_SET_TO_CARRY
      |-> ##1 !DONE_O ##1 DONE_O && CARRY_WE_O)
      else $error("peripheral register access missed its extra cycle");

   skip_discard_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
      SKIP_O |-> !REG_WE_O && !PC_LOAD_O && SKIP_WORDS_O != 2'h0)
      else $error("skip finished with side effects");

endmodule : bit_test_skip_call_exec

// >>> design/bitcall_pkg.sv
// Shared constants and types for the bit-test, skip and call execution unit
package bitcall_pkg;

   // ==========================================================================
   // Widths
   // ==========================================================================
   localparam int DATA_W   = 16;          // Working and file register width
   localparam int BITSEL_W = 4;           // Width of the bit select field
   localparam int TARGET_W = 23;          // Width of a call target
   localparam int HI_W     = TARGET_W - DATA_W;  // Upper target bits
   localparam int CNT_W    = 3;           // Cycle counter width

   // ==========================================================================
   // Operations handed over by the decoder
   // ==========================================================================
   typedef enum logic [2:0] {
      OP_BIT_TEST_SKIP_CLEAR = 3'h0,
      OP_BIT_TEST_SKIP_SET   = 3'h1,
      OP_TEST_SET_TO_CARRY   = 3'h2,
      OP_TEST_SET_TO_ZERO    = 3'h3,
      OP_CALL_LITERAL        = 3'h4,
      OP_CALL_INDIRECT       = 3'h5,
      OP_CALL_INDIRECT_LONG  = 3'h6
   } op_t;

   // ==========================================================================
   // Sequencer states, one-hot
   // ==========================================================================
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } state_t;

   // ==========================================================================
   // Word and cycle counts
   // ==========================================================================
   localparam logic [1:0]       WORDS_ONE      = 2'h1;
   localparam logic [1:0]       WORDS_TWO      = 2'h2;
   localparam logic [CNT_W-1:0] CYC_NO_SKIP    = 3'h1;  // Test with no skip
   localparam logic [CNT_W-1:0] CYC_SKIP_ONE   = 3'h2;  // Skip over one word
   localparam logic [CNT_W-1:0] CYC_SKIP_TWO   = 3'h3;  // Skip over two words
   localparam logic [CNT_W-1:0] CYC_CALL       = 3'h4;  // Any call form
   localparam logic [CNT_W-1:0] CYC_SFR_EXTRA  = 3'h1;  // Peripheral register access

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [DATA_W-1:0]   RST_DATA   = 16'h0000;
   localparam logic [TARGET_W-1:0] RST_TARGET = 23'h000000;
   localparam logic [CNT_W-1:0]    RST_CNT    = 3'h0;

endpackage : bitcall_pkg

// >>> design/bit_pick_set.sv
// Selects one bit of a word and forms the same word with that bit forced high
`timescale 1ns/1ns

module bit_pick_set #(
   parameter int WIDTH = 16,
   parameter int SEL_W = 4
) (
   input  wire logic [WIDTH-1:0] value_i,
   input  wire logic [SEL_W-1:0] sel_i,
   output logic                  bit_o,
   output logic [WIDTH-1:0]      set_o
);

   // ==========================================================================
   // Elaboration check
   // ==========================================================================
   // The select field must address exactly the bits of the word
   if (WIDTH != (1 << SEL_W)) begin : g_bad_width
      $error("bit_pick_set: WIDTH must equal two to the power SEL_W");
   end

   // ==========================================================================
   // Per-bit set logic
   // ==========================================================================
   // One OR gate per bit keeps the set path shallow
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign set_o[i] = value_i[i] | (sel_i == SEL_W'(i));
   end

   // Tested bit before the set takes effect
   assign bit_o = value_i[sel_i];

endmodule : bit_pick_set

// >>> verif/core_datapath_model.sv
// Core fetch and working-register datapath model that consumes the unit's results
`timescale 1ns/1ns

module core_datapath_model (
   input  wire logic                               clk_i,
   input  wire logic                               arst_n_i,
   input  wire logic                               ce_i,
   input  wire logic                               done_i,
   input  wire logic                               skip_i,
   input  wire logic [1:0]                         skip_words_i,
   input  wire logic                               reg_we_i,
   input  wire logic [bitcall_pkg::DATA_W-1:0]     reg_wdata_i,
   input  wire logic                               carry_we_i,
   input  wire logic                               carry_i,
   input  wire logic                               zero_we_i,
   input  wire logic                               zero_i,
   input  wire logic                               sfa_set_i,
   input  wire logic                               pc_load_i,
   input  wire logic [bitcall_pkg::TARGET_W-1:0]   pc_target_i,
   output logic [7:0]                              dropped_o,
   output logic [7:0]                              calls_o,
   output logic [bitcall_pkg::TARGET_W-1:0]        pc_o,
   output logic [bitcall_pkg::DATA_W-1:0]          wreg_o,
   output logic                                    carry_o,
   output logic                                    zero_o
);

   // ==========================================================================
   // Fetch side
   // ==========================================================================
   // Skipped words are only counted, never executed, so a wrong count shows up
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dropped_o <= 8'h00;
      end else if (ce_i && done_i && skip_i) begin
         dropped_o <= dropped_o + {6'h00, skip_words_i};
      end
   end

   // Program counter and stack frame bookkeeping for calls
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pc_o    <= 23'h000000;
         calls_o <= 8'h00;
      end else if (ce_i && done_i && pc_load_i && sfa_set_i) begin
         pc_o    <= pc_target_i;
         calls_o <= calls_o + 8'h01;
      end
   end

   // ==========================================================================
   // Working register and status flags
   // ==========================================================================
   // Each write strobe updates only its own target
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wreg_o  <= 16'h0000;
         carry_o <= 1'b0;
         zero_o  <= 1'b0;
      end else if (ce_i && done_i) begin
         if (reg_we_i) begin
            wreg_o <= reg_wdata_i;
         end
         if (carry_we_i) begin
            carry_o <= carry_i;
         end
         if (zero_we_i) begin
            zero_o <= zero_i;
         end
      end
   end

endmodule : core_datapath_model

// >>> verif/test_bit_test_skip_call_exec.sv
// Self-checking testbench for the bit-test, skip and call execution unit
`timescale 1ns/1ns

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
   $display("BAD t=%0t got %0h exp %0h", $time, (a), (b)); end end

module test_bit_test_skip_call_exec;

   // ==========================================================================
   // Signals and table
   // ==========================================================================
   typedef struct packed {
      logic [2:0]  op;
      logic [3:0]  sel;
      logic [15:0] opnd;
      logic [6:0]  hi;
      logic [5:0]  flg;   // sfr, next two-word, carry we, carry, zero we, zero
      logic [2:0]  cyc;
      logic [1:0]  words;
      logic [1:0]  skw;
      logic [15:0] wdata;
      logic [22:0] tgt;
   } row_t;

   logic clk, arst_n, ce, valid, special_function_register, nxt2, ready, done, skip, reg_we, carry_we, carry;
   logic zero_we, zero, sfa_set, pc_load, core_carry, core_zero;
   bitcall_pkg::op_t op;
   logic [3:0]  sel;
   logic [15:0] opnd, lit_lo, reg_wdata, core_wreg;
   logic [6:0]  opnd_hi, lit_hi;
   logic [1:0]  words, skip_words;
   logic [22:0] pc_target, core_pc;
   logic [7:0]  dropped, calls;
   int          errors, num_checks, n;

   // Literal call target is fixed, so indirect rows show any mix-up of sources
   row_t rows [14] = '{
      '{3'h0, 4'h3, 16'h0008, 7'h00, 6'b000000, 3'h1, 2'h1, 2'h0, 16'h0, 23'h0},
      '{3'h0, 4'h0, 16'hfffe, 7'h00, 6'b000000, 3'h2, 2'h1, 2'h1, 16'h0, 23'h0},
      '{3'h0, 4'hf, 16'h7fff, 7'h00, 6'b010000, 3'h3, 2'h1, 2'h2, 16'h0, 23'h0},
      '{3'h1, 4'hf, 16'h8000, 7'h00, 6'b000000, 3'h2, 2'h1, 2'h1, 16'h0, 23'h0},
      '{3'h1, 4'hf, 16'h8000, 7'h00, 6'b010000, 3'h3, 2'h1, 2'h2, 16'h0, 23'h0},
      '{3'h1, 4'h5, 16'hffdf, 7'h00, 6'b010000, 3'h1, 2'h1, 2'h0, 16'h0, 23'h0},
      '{3'h1, 4'h7, 16'h0080, 7'h00, 6'b110000, 3'h4, 2'h1, 2'h2, 16'h0, 23'h0},
      '{3'h2, 4'h4, 16'h0010, 7'h00, 6'b001100, 3'h1, 2'h1, 2'h0, 16'h0010, 23'h0},
      '{3'h2, 4'h9, 16'h0000, 7'h00, 6'b101000, 3'h2, 2'h1, 2'h0, 16'h0200, 23'h0},
      '{3'h3, 4'h2, 16'h0000, 7'h00, 6'b000011, 3'h1, 2'h1, 2'h0, 16'h0004, 23'h0},
      '{3'h3, 4'hf, 16'h8001, 7'h00, 6'b100010, 3'h2, 2'h1, 2'h0, 16'h8001, 23'h0},
      '{3'h4, 4'h0, 16'h0000, 7'h00, 6'b000000, 3'h4, 2'h2, 2'h0, 16'h0, 23'h5a1234},
      '{3'h5, 4'h0, 16'habcd, 7'h7f, 6'b000000, 3'h4, 2'h1, 2'h0, 16'h0, 23'h00abcd},
      '{3'h6, 4'h0, 16'habcd, 7'h7f, 6'b100000, 3'h4, 2'h1, 2'h0, 16'h0, 23'h7fabcd}};

   bit_test_skip_call_exec u_dut (
      .CLK_SYS_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .ISSUE_VALID_I(valid),
      .ISSUE_READY_O(ready), .ISSUE_OP_I(op), .BIT_SEL_I(sel), .OPERAND_I(opnd),
      .OPERAND_HI_I(opnd_hi), .OPERAND_IS_SFR_I(special_function_register), .NEXT_TWO_WORD_I(nxt2),
      .LIT_LO_I(lit_lo), .LIT_HI_I(lit_hi), .DONE_O(done), .WORDS_O(words), .SKIP_O(skip),
      .SKIP_WORDS_O(skip_words), .REG_WE_O(reg_we), .REG_WDATA_O(reg_wdata),
      .CARRY_WE_O(carry_we), .CARRY_O(carry), .ZERO_WE_O(zero_we), .ZERO_O(zero),
      .SFA_SET_O(sfa_set), .PC_LOAD_O(pc_load), .PC_TARGET_O(pc_target));

   core_datapath_model u_core (
      .clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .done_i(done), .skip_i(skip),
      .skip_words_i(skip_words), .reg_we_i(reg_we), .reg_wdata_i(reg_wdata),
      .carry_we_i(carry_we), .carry_i(carry), .zero_we_i(zero_we), .zero_i(zero),
      .sfa_set_i(sfa_set), .pc_load_i(pc_load), .pc_target_i(pc_target),
      .dropped_o(dropped), .calls_o(calls), .pc_o(core_pc), .wreg_o(core_wreg),
      .carry_o(core_carry), .zero_o(core_zero));

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Offer an op at the falling edge; held until the caller releases it
   task automatic put(input logic [2:0] o, input logic [3:0] s, input logic [15:0] v);
      valid = 1'b1;
      op = bitcall_pkg::op_t'(o);
      sel = s;
      opnd = v;
   endtask : put

   // Bounded wait so a missing completion cannot hang the run
   task automatic wait_done(output int k);
      k = 1;
      while (done !== 1'b1 && k < 12) begin
         @(negedge clk);
         k++;
      end
   endtask : wait_done

   task automatic run_row(input row_t r);
      logic is_ts, is_call;
      is_ts = (r.op == 3'h2) || (r.op == 3'h3);
      is_call = r.op[2];
      `CHK(ready, 1'b1)
      put(r.op, r.sel, r.opnd);
      opnd_hi = r.hi;
      special_function_register = r.flg[5];
      nxt2 = r.flg[4];
      @(negedge clk);
      valid = 1'b0;
      wait_done(n);
      `CHK(n, int'(r.cyc))
      `CHK(words, r.words)
      `CHK(skip, (r.skw != 2'h0))
      `CHK(skip_words, r.skw)
      `CHK(carry_we, r.flg[3])
      `CHK(zero_we, r.flg[1])
      `CHK(reg_we, is_ts)
      `CHK(sfa_set, is_call)
      `CHK(pc_load, is_call)
      if (r.flg[3]) `CHK(carry, r.flg[2])
      if (r.flg[1]) `CHK(zero, r.flg[0])
      if (is_ts) `CHK(reg_wdata, r.wdata)
      if (is_call) `CHK(pc_target, r.tgt)
   endtask : run_row

   // ==========================================================================
   // Clock, watchdog and main sequence
   // ==========================================================================
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // The whole run needs about sixty cycles; this allows ample margin
   initial begin
      #20000;
      errors++;
      give_verdict();
   end

   initial begin
      {arst_n, ce, valid, special_function_register, nxt2, sel, opnd, opnd_hi} = '0;
      op = bitcall_pkg::OP_BIT_TEST_SKIP_CLEAR;
      lit_lo = 16'h1234;
      lit_hi = 7'h5a;
      errors = 0;
      num_checks = 0;
      repeat (3) @(negedge clk);
      `CHK({ready, done, pc_load, words}, 5'b10001)
      arst_n = 1'b1;
      ce = 1'b1;
      foreach (rows[i]) run_row(rows[i]);
      @(negedge clk);
      // Later scenarios use plain operands and a one-word successor
      {special_function_register, nxt2} = 2'b00;
      `CHK(dropped, 8'h08)
      `CHK(calls, 8'h03)
      `CHK(core_pc, 23'h7fabcd)
      `CHK({core_wreg, core_carry, core_zero}, 18'h20004)
      // Second op waits through a busy call and is taken in its final cycle
      put(3'h4, 4'h0, 16'h0000);
      @(negedge clk);
      put(3'h2, 4'h1, 16'h0002);
      `CHK(ready, 1'b0)
      wait_done(n);
      `CHK({n, pc_load, carry_we}, {32'd4, 2'b10})
      @(negedge clk);
      valid = 1'b0;
      `CHK({done, carry_we, carry, reg_wdata}, 19'h70002)
      // Clock enable low for three edges freezes the count, so four cycles remain after it
      put(3'h5, 4'h0, 16'h4321);
      @(negedge clk);
      valid = 1'b0;
      ce = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(done, 1'b0)
      ce = 1'b1;
      wait_done(n);
      `CHK({n, pc_target}, {32'd4, 23'h004321})
      // Reset in mid-call abandons it; no late completion may follow
      @(negedge clk);
      put(3'h6, 4'h0, 16'h5555);
      @(negedge clk);
      valid = 1'b0;
      @(negedge clk);
      arst_n = 1'b0;
      #1;
      `CHK({ready, done, pc_load, words}, 5'b10001)
      @(negedge clk);
      arst_n = 1'b1;
      repeat (6) begin
         @(negedge clk);
         `CHK(done, 1'b0)
      end
      give_verdict();
   end

endmodule : test_bit_test_skip_call_exec
